// ### adcdc_pkg.sv
/*
 * Package for the converter buffer and channel 1-3 input select block:
 * register offsets, field positions, masks, reset values and bus states.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
package adcdc_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0]  OFF_DMA_BUF_CFG  = 8'h00;
	localparam logic [7:0]  OFF_CH_IN_SEL    = 8'h04;
	localparam logic [7:0]  OFF_AUX_CTRL     = 8'h08;
	localparam logic [7:0]  OFF_STATUS       = 8'h0C;
	localparam logic [7:0]  OFF_RESULT_BASE  = 8'h40;
	localparam int          NUM_RESULT       = 16;

	// ------------------------------------------------------------
	// Field positions and implemented-bit masks
	// ------------------------------------------------------------
	localparam int          DMA_EN_BIT       = 8;
	localparam int          WORDS_LSB        = 0;
	localparam logic [15:0] DMA_BUF_CFG_MASK = 16'h0107;
	localparam int          POS_B_UP_LSB     = 11;
	localparam int          NEG_B_LSB        = 9;
	localparam int          POS_B_LOW_BIT    = 8;
	localparam int          POS_A_UP_LSB     = 3;
	localparam int          NEG_A_LSB        = 1;
	localparam int          POS_A_LOW_BIT    = 0;
	localparam logic [15:0] CH_IN_SEL_MASK   = 16'h1F1F;
	localparam int          REF_CFG_LSB      = 0;
	localparam int          ALT_MODE_BIT     = 8;
	localparam logic [15:0] AUX_CTRL_MASK    = 16'h0107;

	// ------------------------------------------------------------
	// Reset values and reference codes
	// ------------------------------------------------------------
	localparam logic [15:0] DMA_BUF_CFG_RST  = 16'h0000;
	localparam logic [15:0] CH_IN_SEL_RST    = 16'h0000;
	localparam logic [15:0] AUX_CTRL_RST     = 16'h0000;
	localparam logic [2:0]  REF_EXT_LOW_A    = 3'h2;
	localparam logic [2:0]  REF_EXT_LOW_B    = 3'h3;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} adcdc_bus_t;

endpackage

// ### adcdc_input_mux.sv
/*
 * Channel 1-3 positive and negative input decode for one sample.
 * Assumes codes are already picked for sample A or B by the caller.
 */
`timescale 1ns/10ps
`default_nettype none
module adcdc_input_mux
	import adcdc_pkg::*;
(
	input  wire logic [2:0] pos_sel,     // Positive select code
	input  wire logic [1:0] neg_sel,     // Negative select code
	input  wire logic [2:0] ref_cfg,     // Reference configuration
	output logic      [4:0] ch1_pos,     // Channel 1 positive input
	output logic      [4:0] ch2_pos,     // Channel 2 positive input
	output logic      [4:0] ch3_pos,     // Channel 3 positive input
	output logic            neg_on_in,   // Negative taken from inputs
	output logic      [4:0] ch1_neg,     // Channel 1 negative input
	output logic      [4:0] ch2_neg,     // Channel 2 negative input
	output logic      [4:0] ch3_neg,     // Channel 3 negative input
	output logic            neg_ext_ref  // Low ref external, else ground
);
	always_comb begin
		casez (pos_sel)
			3'b000:  {ch1_pos, ch2_pos, ch3_pos} = {5'h00, 5'h01, 5'h02}; // see R7
			3'b001:  {ch1_pos, ch2_pos, ch3_pos} = {5'h03, 5'h04, 5'h05}; // see R7
			3'b010:  {ch1_pos, ch2_pos, ch3_pos} = {5'h03, 5'h00, 5'h06}; // see R8
			3'b011:  {ch1_pos, ch2_pos, ch3_pos} = {5'h03, 5'h00, 5'h19}; // see R8
			default: {ch1_pos, ch2_pos, ch3_pos} = {5'h00, 5'h19, 5'h06}; // see R8
		endcase
		neg_on_in = neg_sel[1]; // see R9
		case (neg_sel)
			2'b11:   {ch1_neg, ch2_neg, ch3_neg} = {5'h09, 5'h0A, 5'h0B}; // see R9
			2'b10:   {ch1_neg, ch2_neg, ch3_neg} = {5'h06, 5'h07, 5'h08}; // see R9
			default: {ch1_neg, ch2_neg, ch3_neg} = {5'h00, 5'h00, 5'h00};
		endcase
		// External low reference only for the two matching settings
		neg_ext_ref = !neg_sel[1] && (ref_cfg == REF_EXT_LOW_A || ref_cfg == REF_EXT_LOW_B); // see R10
	end
endmodule
`default_nettype wire

// ### adcdc_dma_slot.sv
/*
 * DMA buffer word offset: each input owns 2**code words; a slot counter
 * steps once per conversion sequence. Assumes one clock, sync reset.
 */
`timescale 1ns/10ps
`default_nettype none
module adcdc_dma_slot
	import adcdc_pkg::*;
(
	input  wire logic        mclk,      // Clock
	input  wire logic        rst_n,     // Sync reset, active low
	input  wire logic        seq_end,   // End of conversion sequence
	input  wire logic [2:0]  words_cd,  // Words per input code
	input  wire logic [4:0]  ain,       // Converted analog input
	output logic      [6:0]  slot,      // Current slot in input area
	output logic      [11:0] offset     // Word offset in DMA buffer
);
	logic [6:0] slot_r;
	logic [6:0] slot_nxt;
	logic [6:0] slot_max;

	always_comb begin
		slot_max = 7'((8'h01 << words_cd) - 8'h01); // see R3
		slot_nxt = slot_r;
		if (seq_end)
			slot_nxt = (slot_r >= slot_max) ? 7'h00 : 7'(slot_r + 7'h01);
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			slot_r <= 7'h00;
		else
			slot_r <= slot_nxt;
	end

	assign slot   = slot_r;
	assign offset = 12'(({7'h00, ain} << words_cd) | {5'h00, slot_r & slot_max}); // see R3
endmodule
`default_nettype wire

// ### adcdc_top.sv
/*
 * Converter result buffering and channel 1-3 input select, with an
 * Avalon-MM register slave. Assumes the converter core pulses conv_done
 * with result and input number, and a DMA engine follows dma_req.
 */
// Function
// R1: DMA mode puts every result in buffer zero
// R2: Otherwise fill sixteen buffers in order, no DMA
// R3: Code n gives 2**n DMA words per input
// R4: Unimplemented bits read zero, ignore writes
// R5: Sample B positive code from bits 12,11,8
// R6: Sample A positive code from bits 4,3,0
// R7: Codes 000, 001 route inputs 0-2, 3-5
// R8: Codes 010, 011, 1xx route documented triples
// R9: Negative codes 11, 10, 0x route inputs/low ref
// R10: Low ref external only for reference 2 or 3
// R11: Sample B only alternates when alternate mode set
`timescale 1ns/10ps
`default_nettype none
module adcdc_top
	import adcdc_pkg::*;
(
	input  wire logic        mclk,            // Clock, 40 MHz
	input  wire logic        rst_n,           // Sync reset, active low
	input  wire logic [7:0]  avs_address,     // Byte address
	input  wire logic        avs_read,        // Read request
	input  wire logic        avs_write,       // Write request
	input  wire logic [31:0] avs_writedata,   // Write data
	input  wire logic [3:0]  avs_byteenable,  // Byte lanes
	output logic      [31:0] avs_readdata,    // Read data
	output logic             avs_waitrequest, // Stall request
	input  wire logic        conv_done,       // Conversion finished
	input  wire logic [15:0] conv_result,     // Conversion result
	input  wire logic [4:0]  conv_input,      // Input converted
	input  wire logic        conv_seq_end,    // Sequence finished
	output logic             sample_b_sel,    // Sample B active
	output logic      [4:0]  ch1_pos,         // Channel 1 positive
	output logic      [4:0]  ch2_pos,         // Channel 2 positive
	output logic      [4:0]  ch3_pos,         // Channel 3 positive
	output logic             neg_on_input,    // Negative from inputs
	output logic      [4:0]  ch1_neg,         // Channel 1 negative
	output logic      [4:0]  ch2_neg,         // Channel 2 negative
	output logic      [4:0]  ch3_neg,         // Channel 3 negative
	output logic             neg_ext_ref,     // Low ref external
	output logic             dma_req,         // DMA transfer request
	output logic      [11:0] dma_offset,      // DMA buffer word offset
	output logic      [15:0] dma_data         // First result buffer
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	adcdc_bus_t  st_r, st_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [15:0] cfg_r, cfg_nxt;
	logic [15:0] sel_r, sel_nxt;
	logic [15:0] aux_r, aux_nxt;
	logic [15:0] res_r [NUM_RESULT];
	logic [3:0]  wptr_r, wptr_nxt;
	logic        smpb_r, smpb_nxt;
	logic        req_r, req_nxt;
	logic [11:0] off_r, off_nxt;
	logic [4:0]  p1_r, p2_r, p3_r, n1_r, n2_r, n3_r;
	logic        non_r, ext_r;
	logic [4:0]  p1_c, p2_c, p3_c, n1_c, n2_c, n3_c;
	logic        non_c, ext_c;
	logic        wr_take;
	logic        dma_mode;
	logic [2:0]  words_cd;
	logic [2:0]  pos_code;
	logic [1:0]  neg_code;
	logic        res_we;
	logic [3:0]  res_idx;
	logic [6:0]  slot;
	logic [11:0] slot_off;
	logic [15:0] lane_mask;

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
		input logic [15:0] lanes, input logic [15:0] impl);
		logic [15:0] keep;
		keep = lanes & impl;
		merge = (old & ~keep) | (nw & keep);
	endfunction

	// ------------------------------------------------------------
	// Bus slave: one wait cycle, answer on the second
	// ------------------------------------------------------------
	// Lanes 1:0 cover the 16-bit registers
	assign wr_take   = (st_r == BUS_ACK) && avs_write;
	assign lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	always_comb begin
		st_nxt    = st_r;
		rdata_nxt = rdata_r;
		case (st_r)
			BUS_IDLE: begin
				if (avs_read || avs_write)
					st_nxt = BUS_ACK;
				rdata_nxt = 32'h0000_0000;
				if (avs_read) begin
					if (avs_address == OFF_DMA_BUF_CFG)
						rdata_nxt = {16'h0000, cfg_r & DMA_BUF_CFG_MASK}; // see R4
					else if (avs_address == OFF_CH_IN_SEL)
						rdata_nxt = {16'h0000, sel_r & CH_IN_SEL_MASK}; // see R4
					else if (avs_address == OFF_AUX_CTRL)
						rdata_nxt = {16'h0000, aux_r & AUX_CTRL_MASK};
					else if (avs_address == OFF_STATUS)
						rdata_nxt = {17'h0_0000, slot, 3'h0, smpb_r, wptr_r};
					else if (avs_address[7:6] == OFF_RESULT_BASE[7:6] && avs_address[1:0] == 2'h0)
						rdata_nxt = {16'h0000, res_r[avs_address[5:2]]};
				end
			end
			BUS_ACK: st_nxt = BUS_IDLE;
			default: st_nxt = BUS_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_r    <= BUS_IDLE;
			rdata_r <= 32'h0000_0000;
		end else begin
			st_r    <= st_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign avs_waitrequest = (st_r != BUS_ACK);
	assign avs_readdata    = rdata_r;

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	always_comb begin
		cfg_nxt = cfg_r;
		sel_nxt = sel_r;
		aux_nxt = aux_r;
		if (wr_take && avs_address == OFF_DMA_BUF_CFG)
			cfg_nxt = merge(cfg_r, avs_writedata[15:0], lane_mask, DMA_BUF_CFG_MASK); // see R4
		if (wr_take && avs_address == OFF_CH_IN_SEL)
			sel_nxt = merge(sel_r, avs_writedata[15:0], lane_mask, CH_IN_SEL_MASK); // see R4
		if (wr_take && avs_address == OFF_AUX_CTRL)
			aux_nxt = merge(aux_r, avs_writedata[15:0], lane_mask, AUX_CTRL_MASK);
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cfg_r <= DMA_BUF_CFG_RST;
			sel_r <= CH_IN_SEL_RST;
			aux_r <= AUX_CTRL_RST;
		end else begin
			cfg_r <= cfg_nxt;
			sel_r <= sel_nxt;
			aux_r <= aux_nxt;
		end
	end

	assign dma_mode = cfg_r[DMA_EN_BIT];
	assign words_cd = cfg_r[WORDS_LSB +: 3];

	// ------------------------------------------------------------
	// Result storage and DMA request
	// ------------------------------------------------------------
	assign res_we  = conv_done;
	assign res_idx = dma_mode ? 4'h0 : wptr_r; // see R1

	always_comb begin
		wptr_nxt = wptr_r;
		req_nxt  = conv_done && dma_mode; // see R1
		off_nxt  = off_r;
		// Pointer parked at zero in DMA mode
		if (dma_mode)
			wptr_nxt = 4'h0;
		else if (conv_done)
			wptr_nxt = 4'(wptr_r + 4'h1); // see R2
		if (conv_done && dma_mode)
			off_nxt = slot_off; // see R3
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wptr_r <= 4'h0;
			req_r  <= 1'b0;
			off_r  <= 12'h000;
		end else begin
			wptr_r <= wptr_nxt;
			req_r  <= req_nxt;
			off_r  <= off_nxt;
		end
	end

	for (genvar i = 0; i < NUM_RESULT; i++) begin : g_res
		logic [15:0] res_nxt;
		always_comb begin
			res_nxt = res_r[i];
			if (res_we && res_idx == 4'(i))
				res_nxt = conv_result; // see R2
		end
		always_ff @(posedge mclk) begin
			if (!rst_n)
				res_r[i] <= 16'h0000;
			else
				res_r[i] <= res_nxt;
		end
	end

	adcdc_dma_slot u_slot (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.seq_end  (conv_seq_end),
		.words_cd (words_cd),
		.ain      (conv_input),
		.slot     (slot),
		.offset   (slot_off)
	);

	assign dma_req    = req_r;
	assign dma_offset = off_r;
	assign dma_data   = res_r[0];

	// ------------------------------------------------------------
	// Sample A/B selection and input routing
	// ------------------------------------------------------------
	always_comb begin
		smpb_nxt = smpb_r;
		if (!aux_r[ALT_MODE_BIT])
			smpb_nxt = 1'b0; // see R11
		else if (conv_done)
			smpb_nxt = !smpb_r; // see R11
		if (smpb_r) begin
			pos_code = {sel_r[POS_B_UP_LSB +: 2], sel_r[POS_B_LOW_BIT]}; // see R5
			neg_code = sel_r[NEG_B_LSB +: 2];
		end else begin
			pos_code = {sel_r[POS_A_UP_LSB +: 2], sel_r[POS_A_LOW_BIT]}; // see R6
			neg_code = sel_r[NEG_A_LSB +: 2];
		end
	end

	// Decode of the active sample, registered below
	adcdc_input_mux u_mux (
		.pos_sel     (pos_code),
		.neg_sel     (neg_code),
		.ref_cfg     (aux_r[REF_CFG_LSB +: 3]),
		.ch1_pos     (p1_c),
		.ch2_pos     (p2_c),
		.ch3_pos     (p3_c),
		.neg_on_in   (non_c),
		.ch1_neg     (n1_c),
		.ch2_neg     (n2_c),
		.ch3_neg     (n3_c),
		.neg_ext_ref (ext_c)
	);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			smpb_r <= 1'b0;
			{p1_r, p2_r, p3_r, n1_r, n2_r, n3_r} <= 30'h0000_0000;
			non_r  <= 1'b0;
			ext_r  <= 1'b0;
		end else begin
			smpb_r <= smpb_nxt;
			{p1_r, p2_r, p3_r, n1_r, n2_r, n3_r} <= {p1_c, p2_c, p3_c, n1_c, n2_c, n3_c};
			non_r  <= non_c;
			ext_r  <= ext_c;
		end
	end

	assign sample_b_sel = smpb_r;
	assign ch1_pos      = p1_r;
	assign ch2_pos      = p2_r;
	assign ch3_pos      = p3_r;
	assign ch1_neg      = n1_r;
	assign ch2_neg      = n2_r;
	assign ch3_neg      = n3_r;
	assign neg_on_input = non_r;
	assign neg_ext_ref  = ext_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	dma_store_a: assert property (conv_done && dma_mode |=> dma_req && dma_data == $past(conv_result)) // see R1
		else $error("DMA mode result not in buffer zero");
	no_dma_a: assert property (!dma_mode && !$past(dma_mode) |-> !dma_req) // see R2
		else $error("DMA request outside DMA mode");
	wptr_wrap_a: assert property (!dma_mode && conv_done && wptr_r == 4'hF && !wr_take |=> wptr_r == 4'h0) // see R2
		else $error("Result pointer did not wrap");
	dma_off_a: assert property (conv_done && dma_mode && !wr_take |=>
		(dma_offset >> $past(words_cd)) == {7'h00, $past(conv_input)}) // see R3
		else $error("DMA offset ignores words per input");
	rsvd_read_a: assert property (st_r == BUS_ACK && $past(avs_address) == OFF_DMA_BUF_CFG |->
		(avs_readdata & 32'hFFFF_FEF8) == 32'h0000_0000) // see R4
		else $error("Unimplemented bits read nonzero");
	pos_b_a: assert property (smpb_r && sel_r[12:11] == 2'b01 && !sel_r[8] |=> ch1_pos == 5'h03 && ch3_pos == 5'h06) // see R5
		else $error("Sample B positive code misformed");
	pos_a_a: assert property (!smpb_r && sel_r[4:3] == 2'b00 && sel_r[0] |=> ch2_pos == 5'h04 && ch3_pos == 5'h05) // see R6
		else $error("Sample A positive code misformed");
	pos_zero_a: assert property (pos_code == 3'b000 |=> {ch1_pos, ch2_pos, ch3_pos} == {5'h00, 5'h01, 5'h02}) // see R7
		else $error("Code 000 routing wrong");
	pos_high_a: assert property (pos_code[2] |=> {ch1_pos, ch2_pos, ch3_pos} == {5'h00, 5'h19, 5'h06}) // see R8
		else $error("Code 1xx routing wrong");
	neg_route_a: assert property (neg_code == 2'b11 |=> neg_on_input && ch2_neg == 5'h0A && !neg_ext_ref) // see R9
		else $error("Negative code 11 routing wrong");
	low_ref_a: assert property (!neg_code[1] |=> neg_ext_ref == ($past(aux_r[2:1]) == 2'b01)) // see R10
		else $error("Low reference choice wrong");
	alt_off_a: assert property (!aux_r[ALT_MODE_BIT] |=> !sample_b_sel) // see R11
		else $error("Sample B used without alternate mode");
	dma_ptr_a: assert property (dma_mode |=> wptr_r == 4'h0) // see R1
		else $error("Result pointer moved in DMA mode");
	buf_fill_a: assert property (!dma_mode && conv_done |=> res_r[$past(wptr_r)] == $past(conv_result)) // see R2
		else $error("Result not stored at pointer");
	wptr_step_a: assert property (!dma_mode && conv_done |=> wptr_r == 4'($past(wptr_r) + 4'h1)) // see R2
		else $error("Result pointer did not step");
	sel_read_a: assert property (st_r == BUS_ACK && $past(avs_address) == OFF_CH_IN_SEL |->
		(avs_readdata & 32'hFFFF_E0E0) == 32'h0000_0000) // see R4
		else $error("Unimplemented select bits read nonzero");
	pos_b_mid_a: assert property (smpb_r && sel_r[12:11] == 2'b01 && sel_r[8] |=> ch3_pos == 5'h19) // see R5
		else $error("Sample B code 011 misformed");
	pos_a_high_a: assert property (!smpb_r && sel_r[4] |=> ch2_pos == 5'h19) // see R6
		else $error("Sample A code 1xx misformed");
	pos_two_a: assert property (pos_code == 3'b010 |=> {ch1_pos, ch2_pos, ch3_pos} == {5'h03, 5'h00, 5'h06}) // see R8
		else $error("Code 010 routing wrong");
	pos_mid_a: assert property (pos_code == 3'b011 |=> {ch1_pos, ch2_pos, ch3_pos} == {5'h03, 5'h00, 5'h19}) // see R8
		else $error("Code 011 routing wrong");
	neg_low_a: assert property (!neg_code[1] |=> !neg_on_input && {ch1_neg, ch2_neg, ch3_neg} == 15'h0000) // see R9
		else $error("Negative code 0x routing wrong");
	neg_mid_a: assert property (neg_code == 2'b10 |=> {ch1_neg, ch2_neg, ch3_neg} == {5'h06, 5'h07, 5'h08}) // see R9
		else $error("Negative code 10 routing wrong");
	ext_ref_a: assert property (!neg_code[1] && aux_r[2:1] == 2'b01 |=> neg_ext_ref) // see R10
		else $error("External low reference not chosen");
	alt_toggle_a: assert property (aux_r[ALT_MODE_BIT] && conv_done |=> sample_b_sel != $past(sample_b_sel)) // see R11
		else $error("Sample did not alternate");
	alt_hold_a: assert property (aux_r[ALT_MODE_BIT] && !conv_done |=> $stable(sample_b_sel)) // see R11
		else $error("Sample changed without conversion");

	// ------------------------------------------------------------
	// Cover points
	// ------------------------------------------------------------
	dma_req_c: cover property (conv_done && dma_mode ##1 dma_req);
	wrap_c: cover property (!dma_mode && conv_done && wptr_r == 4'hF);
	alt_c: cover property (sample_b_sel ##1 !sample_b_sel);
	wr_c: cover property (wr_take && avs_address == OFF_CH_IN_SEL);
	lane_c: cover property (wr_take && avs_byteenable[1:0] == 2'b01);
endmodule
`default_nettype wire

// ### adcdc_conv_model.sv
/*
 * Converter core and DMA sink model for the buffer and input select block.
 * Assumes one clock shared with the block and a sync active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none
module adcdc_conv_model
	import adcdc_pkg::*;
(
	input  wire logic        mclk,          // Clock
	input  wire logic        rst_n,         // Sync reset, active low
	output logic             conv_done,     // Conversion finished
	output logic      [15:0] conv_result,   // Conversion result
	output logic      [4:0]  conv_input,    // Input converted
	output logic             conv_seq_end,  // Sequence finished
	input  wire logic        dma_req,       // DMA transfer request
	input  wire logic [11:0] dma_offset,    // DMA word offset
	input  wire logic [15:0] dma_data,      // Word to move
	output logic      [7:0]  dma_count,     // Requests seen
	output logic      [11:0] dma_last_off,  // Last offset taken
	output logic      [15:0] dma_last_data  // Last word taken
);
	initial begin
		conv_done = 1'b0;
		conv_seq_end = 1'b0;
		conv_result = 16'h0000;
		conv_input = 5'h00;
	end

	// ----------------------------------------
	// Conversion source
	// ----------------------------------------
	// Data lines show the inverse once the strobe has gone
	task automatic convert(input logic [4:0] ain, input logic [15:0] res);
		@(posedge mclk);
		conv_done <= 1'b1;
		conv_input <= ain;
		conv_result <= res;
		@(posedge mclk);
		conv_done <= 1'b0;
		conv_input <= ~ain;
		conv_result <= ~res;
	endtask

	task automatic seq_pulse();
		@(posedge mclk);
		conv_seq_end <= 1'b1;
		@(posedge mclk);
		conv_seq_end <= 1'b0;
	endtask

	// ----------------------------------------
	// DMA sink
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			dma_count <= 8'h00;
		end else if (dma_req) begin
			dma_count <= dma_count + 8'h01;
			dma_last_off <= dma_offset;
			dma_last_data <= dma_data;
		end
	end
endmodule
`default_nettype wire

// ### adc_channel_dma_config_test.sv
/*
 * Self-checking bench for the buffer and channel 1-3 input select block.
 * Assumes the Avalon-MM slave answers after its own wait cycles.
 */
`timescale 1ns/10ps
`default_nettype none
module adc_channel_dma_config_test
	import adcdc_pkg::*;
;
	typedef struct packed {
		logic [15:0] sel;
		logic [30:0] route;
	} adcdc_row_t;

	logic        mclk;
	logic        rst_n;
	logic [7:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        conv_done;
	logic [15:0] conv_result;
	logic [4:0]  conv_input;
	logic        conv_seq_end;
	logic        sample_b_sel;
	logic [4:0]  ch1_pos, ch2_pos, ch3_pos, ch1_neg, ch2_neg, ch3_neg;
	logic        neg_on_input;
	logic        neg_ext_ref;
	logic        dma_req;
	logic [11:0] dma_offset;
	logic [15:0] dma_data;
	logic [7:0]  dma_count;
	logic [11:0] dma_last_off;
	logic [15:0] dma_last_data;
	logic [30:0] route_seen;
	logic [31:0] rd;
	int          fail_count;
	int          checks;
	adcdc_row_t  rows [8] = '{
		'{16'h1F06, {5'h00, 5'h01, 5'h02, 1'b1, 5'h09, 5'h0A, 5'h0B}},
		'{16'h0005, {5'h03, 5'h04, 5'h05, 1'b1, 5'h06, 5'h07, 5'h08}},
		'{16'h0008, {5'h03, 5'h00, 5'h06, 1'b0, 15'h0000}},
		'{16'h000B, {5'h03, 5'h00, 5'h19, 1'b0, 15'h0000}},
		'{16'h0010, {5'h00, 5'h19, 5'h06, 1'b0, 15'h0000}},
		'{16'h0011, {5'h00, 5'h19, 5'h06, 1'b0, 15'h0000}},
		'{16'h0018, {5'h00, 5'h19, 5'h06, 1'b0, 15'h0000}},
		'{16'h001F, {5'h00, 5'h19, 5'h06, 1'b1, 5'h09, 5'h0A, 5'h0B}}};

	assign route_seen = {ch1_pos, ch2_pos, ch3_pos, neg_on_input, ch1_neg, ch2_neg, ch3_neg};

	adcdc_top DUT (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .conv_done(conv_done),
		.conv_result(conv_result), .conv_input(conv_input), .conv_seq_end(conv_seq_end),
		.sample_b_sel(sample_b_sel), .ch1_pos(ch1_pos), .ch2_pos(ch2_pos), .ch3_pos(ch3_pos),
		.neg_on_input(neg_on_input), .ch1_neg(ch1_neg), .ch2_neg(ch2_neg), .ch3_neg(ch3_neg),
		.neg_ext_ref(neg_ext_ref), .dma_req(dma_req), .dma_offset(dma_offset), .dma_data(dma_data));

	adcdc_conv_model model (.mclk(mclk), .rst_n(rst_n), .conv_done(conv_done), .conv_result(conv_result),
		.conv_input(conv_input), .conv_seq_end(conv_seq_end), .dma_req(dma_req), .dma_offset(dma_offset),
		.dma_data(dma_data), .dma_count(dma_count), .dma_last_off(dma_last_off),
		.dma_last_data(dma_last_data));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Holds the request until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] wd, input logic [3:0] be);
		int n;
		n = 0;
		@(posedge mclk);
		avs_address <= a;
		avs_read <= !wr;
		avs_write <= wr;
		avs_writedata <= {16'h0000, wd};
		avs_byteenable <= be;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] wd);
		bus(1'b1, a, wd, 4'hF);
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 16'h0000, 4'hF);
		chk(nm, exp, rd);
	endtask

	task automatic conv(input logic [4:0] ain, input logic [15:0] res);
		model.convert(ain, res);
		@(posedge mclk);
		#1;
	endtask

	task automatic do_reset(input int n);
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (n) @(posedge mclk);
		rst_n <= 1'b1;
	endtask

	// ----------------------------------------
	// Clock, watchdog, tests
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		stop_test();
	end

	initial begin
		fail_count = 0;
		checks = 0;
		rst_n = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		rd_chk("buffer cfg reset", OFF_DMA_BUF_CFG, 32'h0);
		rd_chk("select reset", OFF_CH_IN_SEL, 32'h0);
		wr(OFF_CH_IN_SEL, 16'hFFFF);
		bus(1'b1, OFF_DMA_BUF_CFG, 16'hFFFF, 4'h1);
		rd_chk("buffer cfg lane", OFF_DMA_BUF_CFG, 32'h0007);
		wr(OFF_DMA_BUF_CFG, 16'hFFFF);
		rd_chk("buffer cfg mask", OFF_DMA_BUF_CFG, 32'h0107);
		rd_chk("select mask", OFF_CH_IN_SEL, 32'h1F1F);
		rd_chk("unmapped", 8'h20, 32'h0);
		wr(OFF_DMA_BUF_CFG, 16'h0000);
		foreach (rows[i]) begin
			wr(OFF_CH_IN_SEL, rows[i].sel);
			repeat (2) @(posedge mclk);
			#1;
			chk("routing a", {1'b0, rows[i].route}, {1'b0, route_seen});
		end
		wr(OFF_CH_IN_SEL, 16'h0000);
		for (int r = 0; r < 4; r++) begin
			wr(OFF_AUX_CTRL, 16'(r));
			repeat (2) @(posedge mclk);
			#1;
			chk("low ref", {31'h0, r >= 2}, {31'h0, neg_ext_ref});
		end
		wr(OFF_AUX_CTRL, 16'h0100);
		wr(OFF_CH_IN_SEL, 16'h0F00);
		conv(5'h02, 16'h0055);
		chk("sample b", 32'h1, {31'h0, sample_b_sel});
		chk("routing b", {1'b0, 5'h03, 5'h00, 5'h19, 1'b1, 5'h09, 5'h0A, 5'h0B}, {1'b0, route_seen});
		conv(5'h02, 16'h0056);
		chk("routing back", {1'b0, 5'h00, 5'h01, 5'h02, 1'b0, 15'h0}, {1'b0, route_seen});
		do_reset(2);
		rd_chk("select mid reset", OFF_CH_IN_SEL, 32'h0);
		for (int i = 0; i < 17; i++) model.convert(5'h04, 16'h0100 + 16'(i));
		repeat (2) @(posedge mclk);
		for (int k = 0; k < NUM_RESULT; k++) begin
			rd_chk("result buffer", OFF_RESULT_BASE + 8'(4 * k), (k == 0) ? 32'h0110 : 32'h0100 + k);
		end
		chk("no dma", 32'h0, {24'h0, dma_count});
		rd_chk("status", OFF_STATUS, 32'h0001);
		wr(OFF_DMA_BUF_CFG, 16'h0107);
		conv(5'h01, 16'hA5A5);
		chk("dma data", 32'hA5A5, {16'h0, dma_last_data});
		chk("dma offset 128", 32'd128, {20'h0, dma_last_off});
		rd_chk("first buffer", OFF_RESULT_BASE, 32'hA5A5);
		wr(OFF_DMA_BUF_CFG, 16'h0102);
		conv(5'h03, 16'h1234);
		chk("dma offset 12", 32'd12, {20'h0, dma_last_off});
		model.seq_pulse();
		conv(5'h01, 16'h4321);
		chk("dma offset 5", 32'd5, {20'h0, dma_last_off});
		chk("dma count", 32'h3, {24'h0, dma_count});
		rd_chk("first buffer last", OFF_RESULT_BASE, 32'h4321);
		rd_chk("second buffer", OFF_RESULT_BASE + 8'h04, 32'h0101);
		stop_test();
	end
endmodule
`default_nettype wire
